// ### core/seecc_map.svh
// Purpose: offsets, field positions, command codes and timing counts
// Assumes: 32-bit APB data, byte addresses on PADDR
// Notes: included by the top module only, guarded against double use
`ifndef SEECC_MAP_SVH
`define SEECC_MAP_SVH

`define SEECC_CMD_OFS      8'hb0
`define SEECC_DATA_OFS     8'hb4
`define SEECC_ISTAT_OFS    8'hb8
`define SEECC_IMASK_OFS    8'hbc

`define SEECC_BUSY_BIT     31
`define SEECC_CMD_HI       30
`define SEECC_CMD_LO       28
`define SEECC_TOUT_BIT     9
`define SEECC_LOADED_BIT   8
`define SEECC_IRQ_DONE     0
`define SEECC_IRQ_TOUT     1

`define SEECC_TIMEOUT_MS   30
`define SEECC_CLK_KHZ      25000
`define SEECC_SK_DIV       25

// arbitrary value marking a programmed memory
`define SEECC_SIGNATURE    8'ha5
`define SEECC_LAST_BYTE    3'h6

`define SEECC_OP_READ      2'h2
`define SEECC_OP_WRITE     2'h1
`define SEECC_OP_ERASE     2'h3
`define SEECC_OP_SPECIAL   2'h0
`define SEECC_SUB_ERASE_WRITE_ENABLE     8'hc0
`define SEECC_SUB_ERASE_WRITE_DISABLE     8'h00
`define SEECC_SUB_WRITE_ALL     8'h40
`define SEECC_SUB_ERASE_ALL     8'h80
`define SEECC_LEN_SHORT    5'd11
`define SEECC_LEN_LONG     5'd19

`endif

// ### core/seecc_pkg.sv
// Purpose: shared types of the serial memory command controller
// Assumes: nothing beyond the map header
// Notes: command codes follow the three-bit field of the command register
package seecc_pkg;

    typedef enum logic [2:0] {
        CMD_READ       = 3'b000,
        CMD_EW_DISABLE = 3'b001,
        CMD_EW_ENABLE  = 3'b010,
        CMD_WRITE      = 3'b011,
        CMD_WRITE_ALL  = 3'b100,
        CMD_ERASE      = 3'b101,
        CMD_ERASE_ALL  = 3'b110,
        CMD_RELOAD     = 3'b111
    } seecc_cmd_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SEND = 2'b01,
        ST_GAP  = 2'b10,
        ST_POLL = 2'b11
    } seecc_state_type;

    typedef struct packed {
        logic [4:0]  tx_len;
        logic [18:0] tx_bits;
        logic        rx_en;
    } seecc_frame_type;

endpackage

// ### core/seecc_top.sv
// Purpose: APB controller running single commands on a serial memory
// Assumes: memory answers ready by driving the data line high
// Notes: a reload runs by itself after reset
`timescale 1ns/1ps
`include "seecc_map.svh"
module seecc_top #(
    parameter int         TIMEOUT_CYCLES = `SEECC_TIMEOUT_MS *
                                           `SEECC_CLK_KHZ,
    parameter int         SK_DIV         = `SEECC_SK_DIV,
    parameter logic [7:0] SIGNATURE      = `SEECC_SIGNATURE
) (
    input  wire logic        SYS_CLK,
    input  wire logic        SRST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic             PREADY,
    output logic [31:0]      PRDATA,
    output logic             PSLVERR,
    output logic             IRQ,
    output logic             NVM_SELECT,
    output logic             NVM_SERIAL_CLOCK,
    input  wire logic        NVM_SERIAL_DATA_LINE_IN,
    output logic             NVM_SERIAL_DATA_LINE_OUT,
    output logic             NVM_SERIAL_DATA_LINE_OE,
    output logic [47:0]      STATION_ADDRESS
);
    seecc_pkg::seecc_state_type state;
    seecc_pkg::seecc_cmd_type   cmd;
    seecc_pkg::seecc_cmd_type   run;
    seecc_pkg::seecc_frame_type frame;

    logic        busy;
    logic        tout;
    logic        loaded;
    logic        boot;
    logic [7:0]  addr;
    logic [7:0]  data;
    logic [1:0]  istat;
    logic [1:0]  imask;
    logic [31:0] timer;
    logic [2:0]  idx;
    logic        w_start;
    logic        w_done;
    logic [7:0]  w_rx;
    logic [31:0] rdata;
    logic        mapped;
    logic        access;
    logic        wr_go;
    logic        wr_cmd;
    logic        wr_data;
    logic        wr_stat;
    logic        wr_mask;
    logic        di;
    logic        send_done;
    logic        poll_ok;
    logic        poll_to;
    logic        rl_step;
    logic        rl_bad;
    logic        rl_last;
    logic        finish;
    logic        launch;

    function automatic logic polls(input seecc_pkg::seecc_cmd_type c);
        return c == seecc_pkg::CMD_WRITE || c == seecc_pkg::CMD_WRITE_ALL ||
               c == seecc_pkg::CMD_ERASE || c == seecc_pkg::CMD_ERASE_ALL;
    endfunction

    function automatic seecc_pkg::seecc_frame_type build(
        input seecc_pkg::seecc_cmd_type c,
        input logic [7:0]               a,
        input logic [7:0]               d
    );
        seecc_pkg::seecc_frame_type f;
        logic [1:0]                 op;
        logic [7:0]                 sub;
        op  = `SEECC_OP_SPECIAL;
        sub = a;
        unique case (c)
            seecc_pkg::CMD_READ:       op  = `SEECC_OP_READ;
            seecc_pkg::CMD_RELOAD:     op  = `SEECC_OP_READ;
            seecc_pkg::CMD_WRITE:      op  = `SEECC_OP_WRITE;
            seecc_pkg::CMD_ERASE:      op  = `SEECC_OP_ERASE;
            seecc_pkg::CMD_EW_ENABLE:  sub = `SEECC_SUB_ERASE_WRITE_ENABLE;
            seecc_pkg::CMD_EW_DISABLE: sub = `SEECC_SUB_ERASE_WRITE_DISABLE;
            seecc_pkg::CMD_WRITE_ALL:  sub = `SEECC_SUB_WRITE_ALL;
            seecc_pkg::CMD_ERASE_ALL:  sub = `SEECC_SUB_ERASE_ALL;
        endcase
        f.tx_bits = {1'b1, op, sub, d};
        f.tx_len  = (c == seecc_pkg::CMD_WRITE ||
                     c == seecc_pkg::CMD_WRITE_ALL) ?
                    `SEECC_LEN_LONG : `SEECC_LEN_SHORT;
        f.rx_en   = c == seecc_pkg::CMD_READ || c == seecc_pkg::CMD_RELOAD;
        return f;
    endfunction

    // ---- APB slave: one wait state, commit when PREADY is seen high
    assign access  = PSEL && PENABLE;
    assign wr_go   = access && PREADY && PWRITE;
    assign wr_cmd  = wr_go && PADDR == `SEECC_CMD_OFS;
    assign wr_data = wr_go && PADDR == `SEECC_DATA_OFS;
    assign wr_stat = wr_go && PADDR == `SEECC_ISTAT_OFS;
    assign wr_mask = wr_go && PADDR == `SEECC_IMASK_OFS;

    always_comb begin
        rdata  = 32'h0;
        mapped = 1'b1;
        case (PADDR)
            `SEECC_CMD_OFS:   rdata = {busy, cmd, 18'h0, tout, loaded, addr};
            `SEECC_DATA_OFS:  rdata = {24'h0, data};
            `SEECC_ISTAT_OFS: rdata = {30'h0, istat};
            `SEECC_IMASK_OFS: rdata = {30'h0, imask};
            default:          mapped = 1'b0;
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= access && !PREADY;
            if (access && !PREADY) begin
                PRDATA  <= PWRITE ? 32'h0 : rdata;
                PSLVERR <= !mapped;
            end
        end
    end

    // ---- operation events
    assign di        = NVM_SERIAL_DATA_LINE_IN;
    assign send_done = state == seecc_pkg::ST_SEND && w_done;
    assign poll_ok   = state == seecc_pkg::ST_POLL && di;
    assign poll_to   = state == seecc_pkg::ST_POLL && !di &&
                       timer == 32'(TIMEOUT_CYCLES - 1);
    assign rl_step   = send_done && run == seecc_pkg::CMD_RELOAD;
    assign rl_bad    = rl_step && idx == 3'h0 && w_rx != SIGNATURE;
    assign rl_last   = rl_step && idx == `SEECC_LAST_BYTE;
    assign finish    = poll_ok || poll_to || rl_bad || rl_last ||
                       (send_done && run != seecc_pkg::CMD_RELOAD &&
                        !polls(run));
    assign launch    = state == seecc_pkg::ST_IDLE && (boot || busy);

    // command fields are locked while an operation runs
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            cmd  <= seecc_pkg::CMD_READ;
            addr <= 8'h0;
        end else if (wr_cmd && !busy) begin
            cmd  <= seecc_pkg::seecc_cmd_type'(
                        PWDATA[`SEECC_CMD_HI:`SEECC_CMD_LO]);
            addr <= PWDATA[7:0];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            busy <= 1'b0;
            boot <= 1'b1;
        end else begin
            if (launch && boot) begin
                boot <= 1'b0;
                busy <= 1'b1;
            end else if (wr_cmd && !busy && PWDATA[`SEECC_BUSY_BIT]) begin
                busy <= 1'b1;
            end else if (finish) begin
                busy <= 1'b0;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            data <= 8'h0;
        end else if (send_done && run == seecc_pkg::CMD_READ) begin
            data <= w_rx;
        end else if (wr_data && !busy) begin
            data <= PWDATA[7:0];
        end
    end

    // a time-out in the same cycle as the clear write still sets
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            tout <= 1'b0;
        end else if (poll_to) begin
            tout <= 1'b1;
        end else if (wr_cmd && PWDATA[`SEECC_TOUT_BIT]) begin
            tout <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            loaded          <= 1'b0;
            STATION_ADDRESS <= 48'h0;
        end else begin
            if (launch && (boot || cmd == seecc_pkg::CMD_RELOAD)) begin
                loaded <= 1'b0;
            end else if (rl_last) begin
                loaded <= 1'b1;
            end
            if (rl_step && idx != 3'h0) begin
                STATION_ADDRESS[(idx - 3'h1) * 8 +: 8] <= w_rx;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            istat <= 2'h0;
            imask <= 2'h0;
            IRQ   <= 1'b0;
        end else begin
            istat <= (istat & ~(wr_stat ? PWDATA[1:0] : 2'h0)) |
                     {poll_to, finish};
            if (wr_mask) begin
                imask <= PWDATA[1:0];
            end
            // one cycle behind the status bits
            IRQ <= |(istat & imask);
        end
    end

    // ---- sequencer
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            state      <= seecc_pkg::ST_IDLE;
            run        <= seecc_pkg::CMD_READ;
            frame      <= '0;
            w_start    <= 1'b0;
            NVM_SELECT <= 1'b0;
            timer      <= 32'h0;
            idx        <= 3'h0;
        end else begin
            w_start <= 1'b0;
            timer   <= timer + 32'h1;
            unique case (state)
                seecc_pkg::ST_IDLE: begin
                    if (launch) begin
                        run        <= boot ? seecc_pkg::CMD_RELOAD : cmd;
                        frame      <= build(boot ? seecc_pkg::CMD_RELOAD : cmd,
                                            boot ? 8'h0 : addr, data);
                        idx        <= 3'h0;
                        w_start    <= 1'b1;
                        NVM_SELECT <= 1'b1;
                        state      <= seecc_pkg::ST_SEND;
                    end
                end
                seecc_pkg::ST_SEND: begin
                    timer <= 32'h0;
                    if (finish) begin
                        NVM_SELECT <= 1'b0;
                        state      <= seecc_pkg::ST_IDLE;
                    end else if (send_done) begin
                        NVM_SELECT <= 1'b0;
                        state      <= seecc_pkg::ST_GAP;
                    end
                end
                seecc_pkg::ST_GAP: begin
                    // deselect long enough for the memory to start its cycle
                    if (timer == 32'(SK_DIV - 1)) begin
                        timer      <= 32'h0;
                        NVM_SELECT <= 1'b1;
                        if (run == seecc_pkg::CMD_RELOAD) begin
                            idx     <= idx + 3'h1;
                            frame   <= build(run, {5'h0, idx + 3'h1}, 8'h0);
                            w_start <= 1'b1;
                            state   <= seecc_pkg::ST_SEND;
                        end else begin
                            state <= seecc_pkg::ST_POLL;
                        end
                    end
                end
                seecc_pkg::ST_POLL: begin
                    if (finish) begin
                        NVM_SELECT <= 1'b0;
                        state      <= seecc_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    seecc_wire #(
        .DIV (SK_DIV)
    ) u_wire (
        .clk   (SYS_CLK),
        .srst  (SRST),
        .start (w_start),
        .frame (frame),
        .di    (di),
        .done  (w_done),
        .sk    (NVM_SERIAL_CLOCK),
        .dout  (NVM_SERIAL_DATA_LINE_OUT),
        .doe   (NVM_SERIAL_DATA_LINE_OE),
        .rx    (w_rx)
    );

    // ---- checks
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (SRST);

    property p_timer_bound;
        state == seecc_pkg::ST_POLL |-> timer < 32'(TIMEOUT_CYCLES);
    endproperty
    a_timer_bound: assert property (p_timer_bound)
        else $error("poll ran past the time-out");

    property p_tout_cause;
        $rose(tout) |-> $past(state) == seecc_pkg::ST_POLL &&
                        $past(timer) == 32'(TIMEOUT_CYCLES - 1);
    endproperty
    a_tout_cause: assert property (p_tout_cause)
        else $error("time-out flag set without a full wait");

    property p_ready_ends;
        poll_ok |=> state == seecc_pkg::ST_IDLE && !busy && !$rose(tout);
    endproperty
    a_ready_ends: assert property (p_ready_ends)
        else $error("ready line did not end the command");

    property p_tout_cmds;
        $rose(tout) |-> polls($past(run));
    endproperty
    a_tout_cmds: assert property (p_tout_cmds)
        else $error("time-out on a command that cannot time out");

    property p_busy_start;
        $rose(busy) |-> $past(boot) ||
                        $past(wr_cmd && PWDATA[`SEECC_BUSY_BIT]);
    endproperty
    a_busy_start: assert property (p_busy_start)
        else $error("busy rose without a start");

    property p_busy_hold;
        state != seecc_pkg::ST_IDLE |-> busy;
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("busy dropped while an operation runs");

    property p_read_data;
        send_done && run == seecc_pkg::CMD_READ |=>
            data == $past(w_rx) && !busy;
    endproperty
    a_read_data: assert property (p_read_data)
        else $error("read result not in the data register");

    property p_loaded;
        $rose(loaded) |-> $past(rl_step) &&
                          $past(idx) == `SEECC_LAST_BYTE;
    endproperty
    a_loaded: assert property (p_loaded)
        else $error("loaded flag without a full reload");

    property p_write_frame;
        w_start && run == seecc_pkg::CMD_WRITE |->
            frame.tx_bits == {1'b1, `SEECC_OP_WRITE, addr, data};
    endproperty
    a_write_frame: assert property (p_write_frame)
        else $error("write frame carries wrong address or data");

    c_timeout: cover property (poll_to);
    c_reload:  cover property (rl_last);
    c_read:    cover property (send_done && run == seecc_pkg::CMD_READ);
endmodule

// ### core/seecc_wire.sv
// Purpose: shifts one serial frame out and optionally eight bits back in
// Assumes: start is a one-cycle pulse with frame valid in the same cycle
// Notes: data changes while sk is low, input is sampled on the rising sk
`timescale 1ns/1ps
module seecc_wire #(
    parameter int DIV = 25
) (
    input  wire logic                    clk,
    input  wire logic                    srst,
    input  wire logic                    start,
    input  wire seecc_pkg::seecc_frame_type frame,
    input  wire logic                    di,
    output logic                         done,
    output logic                         sk,
    output logic                         dout,
    output logic                         doe,
    output logic [7:0]                   rx
);
    logic [7:0]  cnt;
    logic        active;
    logic        phase;
    logic [18:0] sh;
    logic [4:0]  txl;
    logic [3:0]  rxl;
    logic        tick;
    logic        last;

    assign tick = active && (cnt == 8'(DIV - 1));
    assign last = (txl == 5'h1 && rxl == 4'h0) ||
                  (txl == 5'h0 && rxl == 4'h1);

    always_ff @(posedge clk) begin
        if (srst || !active || tick) begin
            cnt <= 8'h0;
        end else begin
            cnt <= cnt + 8'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            active <= 1'b0;
            phase  <= 1'b0;
            sk     <= 1'b0;
            dout   <= 1'b0;
            doe    <= 1'b0;
            done   <= 1'b0;
            sh     <= 19'h0;
            txl    <= 5'h0;
            rxl    <= 4'h0;
            rx     <= 8'h0;
        end else begin
            done <= 1'b0;
            if (start) begin
                active <= 1'b1;
                phase  <= 1'b0;
                sk     <= 1'b0;
                sh     <= frame.tx_bits;
                dout   <= frame.tx_bits[18];
                doe    <= 1'b1;
                txl    <= frame.tx_len;
                rxl    <= frame.rx_en ? 4'h8 : 4'h0;
            end else if (tick && !phase) begin
                sk    <= 1'b1;
                phase <= 1'b1;
                if (txl == 5'h0) begin
                    rx <= {rx[6:0], di};
                end
            end else if (tick) begin
                sk    <= 1'b0;
                phase <= 1'b0;
                if (txl != 5'h0) begin
                    txl  <= txl - 5'h1;
                    sh   <= {sh[17:0], 1'b0};
                    dout <= sh[17];
                    // hand the line to the memory for its reply
                    if (txl == 5'h1) begin
                        doe <= 1'b0;
                    end
                end else begin
                    rxl <= rxl - 4'h1;
                end
                if (last) begin
                    active <= 1'b0;
                    done   <= 1'b1;
                    doe    <= 1'b0;
                    dout   <= 1'b0;
                end
            end
        end
    end
endmodule

// ### tb/seecc_nvm_model.sv
// Purpose: behavioural serial memory on the shared data line
// Assumes: start bit, 2 op bits, 8 address bits, optional 8 data bits
// Notes: busy status is shown only while selected and unclocked
`timescale 1ns/1ps
module seecc_nvm_model #(
    parameter logic [7:0] SIG  = 8'ha5,
    parameter int         BUSY = 2000
) (
    input  wire logic cs,
    input  wire logic sk,
    input  wire logic oe,
    input  wire logic dout,
    input  wire logic present,
    input  wire logic pull,
    output logic      line
);
    logic [7:0]  m [256];
    logic [18:0] sr = '0;
    logic [1:0]  op = 2'b00;
    logic [7:0]  ad = 8'h00;
    logic        ew = 1'b0;
    logic        st = 1'b0;
    logic        bsy = 1'b0;
    logic        drv = 1'b0;
    logic        dv = 1'b0;
    logic        wc;
    int          n = 0;
    // a released line falls back to the board pull, never the last bit
    assign line = oe ? dout : (cs && st) ? !bsy : drv ? dv : pull;
    initial begin
        foreach (m[i]) m[i] = (i > 0 && i < 7) ? 8'(i * 17) : 8'h00;
        m[0] = SIG;
    end
    always @(posedge cs) begin
        n = 0;
        sr = '0;
    end
    always @(posedge sk) begin
        if (cs && present && (n > 0 || line)) begin
            st = 1'b0;
            sr = {sr[17:0], line};
            n++;
            if (n == 11) begin
                op = sr[9:8];
                ad = sr[7:0];
            end
        end
    end
    // read data leaves msb first while the clock is low
    always @(negedge sk) begin
        drv = cs && present && op == 2'b10 && n >= 11 && n < 19;
        if (drv) dv = m[ad][18 - n];
    end
    always @(negedge cs) begin
        drv = 1'b0;
        wc = present && ew && n >= 11 &&
             (op[0] || (op == 2'b00 && (ad[7] ^ ad[6])));
        if (present && n == 11 && op == 2'b00 && ad[7] == ad[6]) begin
            ew = ad[7];
        end
        if (wc) begin
            st = 1'b1;
            bsy = 1'b1;
            bsy <= #BUSY 1'b0;
            foreach (m[i]) begin
                if (op == 2'b01 && i == ad) m[i] = sr[7:0];
                if (op == 2'b11 && i == ad) m[i] = 8'hff;
                if (op == 2'b00) m[i] = ad[6] ? sr[7:0] : 8'hff;
            end
        end
    end
endmodule

// ### tb/seecc_top_bench.sv
// Purpose: self-checking bench for the serial memory command controller
// Assumes: memory model answers on the shared data line
// Notes: short time-out and serial divider keep the run brief
`timescale 1ns/1ps
`define CHK(s, e, g) begin n_compared++; if ((g) !== (e)) begin \
    n_errors++; $display("unexpected %s exp %h got %h", s, e, g); end end
module seecc_top_bench;
    localparam logic [7:0] SIG = 8'h5c; // arbitrary
    localparam int         TOC = 200;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [7:0]  pa = 8'h00;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prd;
    logic [31:0] rd;
    logic        prdy, perr, er, irq, cs, sk, dout, oe, line;
    logic        present = 1'b1;
    logic        pull = 1'b1;
    logic [47:0] sa;
    time         t0;
    int          n_errors = 0;
    int          n_compared = 0;
    always #20 clk = ~clk;
    seecc_top #(.TIMEOUT_CYCLES(TOC), .SK_DIV(2), .SIGNATURE(SIG)) dut (
        .SYS_CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PREADY(prdy),
        .PRDATA(prd), .PSLVERR(perr), .IRQ(irq), .NVM_SELECT(cs),
        .NVM_SERIAL_CLOCK(sk), .NVM_SERIAL_DATA_LINE_IN(line),
        .NVM_SERIAL_DATA_LINE_OUT(dout), .NVM_SERIAL_DATA_LINE_OE(oe),
        .STATION_ADDRESS(sa));
    seecc_nvm_model #(.SIG(SIG)) mem (.cs(cs), .sk(sk), .oe(oe),
        .dout(dout), .present(present), .pull(pull), .line(line));
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        // no wait-state count assumed: only the watchdog ends a stuck bus
        do begin
            @(posedge clk);
        end while (prdy !== 1'b1);
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic idle();
        do begin
            apb(1'b0, 8'hb0, 32'h0);
        end while (rd[31] !== 1'b0);
    endtask
    task automatic run(input logic [2:0] c, input logic [7:0] a);
        apb(1'b1, 8'hb0, {1'b1, c, 20'h0, a});
        idle();
    endtask
    task automatic wd(input logic [7:0] d);
        apb(1'b1, 8'hb4, {24'h0, d});
    endtask
    task automatic t_boot();
        idle();
        `CHK("loaded", 1'b1, rd[8])
        `CHK("station", 48'h665544332211, sa)
        apb(1'b0, 8'hc0, 32'h0);
        `CHK("unmapped", 33'h100000000, {er, rd})
        apb(1'b1, 8'hb8, 32'h3);
        $display("test boot done");
    endtask
    task automatic t_wr();
        run(3'b010, 8'h00);
        wd(8'h5a);
        apb(1'b1, 8'hb0, {1'b1, 3'b011, 20'h0, 8'hff});
        apb(1'b0, 8'hb0, 32'h0);
        `CHK("busy", 1'b1, rd[31])
        wd(8'h11);
        idle();
        apb(1'b0, 8'hb4, 32'h0);
        `CHK("locked", 32'h5a, rd)
        `CHK("wr", 8'h5a, mem.m[255])
        wd(8'h00);
        run(3'b000, 8'hff);
        apb(1'b0, 8'hb4, 32'h0);
        `CHK("rd", 32'h5a, rd)
        run(3'b101, 8'hff);
        `CHK("erase", 16'hff00, {mem.m[255], mem.m[254]})
        $display("test write done");
    endtask
    task automatic t_all();
        // drop done bits of earlier commands so the irq check means this one
        apb(1'b1, 8'hb8, 32'h3);
        apb(1'b1, 8'hbc, 32'h1);
        wd(8'h3c);
        run(3'b100, 8'h00);
        `CHK("write_all", 16'h3c3c, {mem.m[0], mem.m[200]})
        `CHK("irq", 1'b1, irq)
        apb(1'b1, 8'hb8, 32'h1);
        repeat (3) @(posedge clk);
        `CHK("irq_clr", 1'b0, irq)
        run(3'b110, 8'h00);
        `CHK("erase_all", 8'hff, mem.m[77])
        run(3'b111, 8'h00);
        `CHK("badsig", 1'b0, rd[8])
        wd(SIG);
        run(3'b011, 8'h00);
        run(3'b111, 8'h00);
        `CHK("reload", 49'h1ffffffffffff, {rd[8], sa})
        run(3'b001, 8'h00);
        wd(8'h77);
        run(3'b011, 8'h05);
        `CHK("erase_write_disable", 8'hff, mem.m[5])
        apb(1'b1, 8'hbc, 32'h0);
        $display("test all done");
    endtask
    task automatic t_tmo();
        present <= 1'b0;
        pull <= 1'b0;
        run(3'b010, 8'h00);
        `CHK("erase_write_enable_tmo", 1'b0, rd[9])
        run(3'b000, 8'h03);
        `CHK("rd_tmo", 1'b0, rd[9])
        t0 = $time;
        run(3'b011, 8'h03);
        `CHK("tmo", 1'b1, rd[9])
        `CHK("tmo_len", 1'b1, ($time - t0) >= TOC * 40)
        apb(1'b0, 8'hb8, 32'h0);
        `CHK("ist_tmo", 1'b1, rd[1])
        apb(1'b1, 8'hb0, 32'h200);
        apb(1'b0, 8'hb0, 32'h0);
        `CHK("tmo_clr", 1'b0, rd[9])
        pull <= 1'b1;
        run(3'b101, 8'h03);
        `CHK("pulled_up", 1'b0, rd[9])
        present <= 1'b1;
        $display("test timeout done");
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // the whole sequence needs a few thousand cycles
    initial begin
        #2000000;
        n_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        t_boot();
        t_wr();
        t_all();
        t_tmo();
        tally_and_finish();
    end
endmodule
